//--- rtl/dop_pkg.sv
// Constants shared by the depth output configuration block.
// Assumes a 32-bit APB register bus; each register index maps to byte address index*4.
package dop_pkg;
  // Register indices, address width and register width
  localparam logic [7:0]  IDX_SYNC_DELAY   = 8'hd6;
  localparam logic [7:0]  IDX_ENGINE_OPT   = 8'hd9;
  localparam logic [7:0]  IDX_LINE_TIMING  = 8'hdc;
  localparam logic [7:0]  IDX_FRAME_BLANK  = 8'hdd;
  localparam logic [7:0]  IDX_CONTROL      = 8'he4;
  localparam logic [7:0]  IDX_STATUS       = 8'he5;
  localparam int          ADDR_W           = 12;
  localparam int          REG_W            = 24;
  // Reset words
  localparam logic [23:0] RST_SYNC_DELAY   = 24'h400001;
  localparam logic [23:0] RST_ENGINE_OPT   = 24'h00000c;
  localparam logic [23:0] RST_LINE_TIMING  = 24'h480280;
  localparam logic [23:0] RST_FRAME_BLANK  = 24'h01883c;
  localparam logic [23:0] RST_CONTROL      = 24'h000000;
  // Field positions
  localparam int SYNC_DELAY_LSB   = 0;
  localparam int SYNC_DELAY_W     = 22;
  localparam int COL_BIN_LSB      = 20;
  localparam int ROW_BIN_LSB      = 18;
  localparam int BIN_W            = 2;
  localparam int SHIFT_EN_BIT     = 16;
  localparam int BIN_SIZE_BIT     = 15;
  localparam int TEST_PAT_BIT     = 14;
  localparam int AMB_FLOOR_LSB    = 6;
  localparam int AMB_FLOOR_W      = 4;
  localparam int SHIFT_AMT_LSB    = 0;
  localparam int SHIFT_AMT_W      = 3;
  localparam int PULSE_CODE_LSB   = 21;
  localparam int PULSE_CODE_W     = 3;
  localparam int LINE_BLANK_LSB   = 11;
  localparam int LINE_ACTIVE_LSB  = 1;
  localparam int LINE_W           = 10;
  localparam int VBLANK_LSB       = 9;
  localparam int VBLANK_W         = 6;
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_SYNC_BIT    = 1;
  // Minimum legal field values
  localparam logic [9:0]  LINE_BLANK_MIN = 10'h002;
  localparam logic [5:0]  VBLANK_MIN     = 6'h02;
  localparam logic [21:0] SYNC_DELAY_MIN = 22'h000001;
  // Frame pulse length for codes beyond the table
  localparam logic [5:0]  PULSE_LINES_DFLT = 6'h04;
  localparam logic [2:0]  PULSE_CODE_MAX   = 3'h5;
  // Timing generator states
  typedef enum logic {DOP_IDLE, DOP_RUN} dop_tg_state_t;
endpackage

//--- rtl/dop_sync_delay.sv
// Synchroniser and programmable delay for the external frame-sync pin.
// Assumes the pin is asynchronous to core_clk_i; delay is reloaded on each new edge.
`timescale 1ns/1ns
`default_nettype none
module dop_sync_delay
  import dop_pkg::*;
(
  // Clock and reset
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_b_i,
  // Pin and setting
  input  wire logic                    ext_sync_i,
  input  wire logic [SYNC_DELAY_W-1:0] delay_i,
  // Delayed frame start
  output logic                         frame_sync_o
);
  logic                    meta_q;
  logic                    sync_q;
  logic                    prev_q;
  logic                    busy_q;
  logic [SYNC_DELAY_W-1:0] cnt_q;
  logic [SYNC_DELAY_W-1:0] load;
  logic                    edge_seen;

  // First stage is read only by the second stage
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= ext_sync_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign edge_seen = sync_q && !prev_q;
  // Zero would mean no delay at all; the shortest legal delay is one cycle
  assign load = (delay_i < SYNC_DELAY_MIN) ? SYNC_DELAY_MIN : delay_i;  // [R1]

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      busy_q       <= 1'b0;
      cnt_q        <= '0;
      frame_sync_o <= 1'b0;
    end
    else
    begin
      frame_sync_o <= 1'b0;
      if (edge_seen)
      begin
        busy_q <= 1'b1;
        cnt_q  <= load;  // [R1]
      end
      else if (busy_q)
      begin
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == SYNC_DELAY_MIN)
        begin
          busy_q       <= 1'b0;
          frame_sync_o <= 1'b1;  // [R1]
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/dop_output_ctrl.sv
// Depth output configuration registers, depth post-processing and parallel port timing.
// Assumes APB on core_clk_i; pixel data inputs come from the depth engine on the same clock.
//
// Summary of operation
// R1: Delay internal frame start after external sync.
// R2: Software writes documented values into reserved bits.
// R3: Merge two-to-the-field adjacent columns when binning.
// R4: Merge two-to-the-field adjacent rows when binning.
// R5: Left-shift I and Q when scaling enabled.
// R6: Size mode keeps frame, else binning shrinks.
// R7: Ambient below floor forces phase to zero.
// R8: Frame pulse length in lines from code.
// R9: Line blank length in pixels, minimum two.
// R10: Active line length in pixels from field.
// R11: Test pattern replaces depth data when enabled.
// R12: Sync mode aligns frames, free-runs without sync.
// R13: Programmable blank lines before first line, minimum two.
// R14: Registers reset to their documented words.
`timescale 1ns/1ns
`default_nettype none
module dop_output_ctrl
  import dop_pkg::*;
#(
  parameter int PIX_DIV    = 4,
  parameter int FRAME_ROWS = 64,
  parameter int DATA_W     = 12
)
(
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_b_i,
  // APB slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [ADDR_W-1:0]     paddr_i,
  input  wire logic [31:0]           pwdata_i,
  input  wire logic [3:0]            pstrb_i,
  output logic [31:0]                prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // External frame sync pin
  input  wire logic                  external_frame_sync_input_i,
  // Depth engine interface
  input  wire logic signed [DATA_W-1:0] raw_i_i,
  input  wire logic signed [DATA_W-1:0] raw_q_i,
  input  wire logic [DATA_W-1:0]     phase_i,
  input  wire logic [DATA_W-1:0]     amplitude_i,
  input  wire logic [AMB_FLOOR_W-1:0] ambient_i,
  output logic signed [DATA_W+6:0]   scaled_i_o,
  output logic signed [DATA_W+6:0]   scaled_q_o,
  output logic [3:0]                 column_bin_o,
  output logic [3:0]                 row_bin_o,
  // Parallel pixel port
  output logic                       frame_start_pulse_o,
  output logic                       line_start_pulse_o,
  output logic                       pixel_valid_o,
  output logic [2*DATA_W-1:0]        pixel_data_o,
  output logic                       pixel_clk_en_o
);
  if (PIX_DIV < 1 || PIX_DIV > 255)
    $error("PIX_DIV out of range");
  if (FRAME_ROWS < 1 || FRAME_ROWS > 1000)
    $error("FRAME_ROWS out of range");
  if (DATA_W < 4 || DATA_W > 16)
    $error("DATA_W out of range");

  localparam logic [9:0] ROWS = 10'(FRAME_ROWS);
  localparam logic [7:0] DIV_LAST = 8'(PIX_DIV - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [REG_W-1:0] sync_delay_q;
  logic [REG_W-1:0] engine_opt_q;
  logic [REG_W-1:0] line_timing_q;
  logic [REG_W-1:0] frame_blank_q;
  logic [1:0]       control_q;
  logic [7:0]       frame_count_q;
  logic             running;
  logic [7:0]       reg_idx;
  logic             wr_en;
  logic             rd_hit;

  // Zero wait states: every access completes in its first access-phase cycle
  // Only aligned addresses inside the low 1 KB window decode to a register
  assign reg_idx  = paddr_i[9:2];
  assign pready_o = 1'b1;
  assign wr_en    = psel_i && penable_i && pwrite_i;
  assign rd_hit   = (paddr_i[1:0] == 2'h0) && (paddr_i[ADDR_W-1:10] == '0) &&
                    (reg_idx == IDX_SYNC_DELAY || reg_idx == IDX_ENGINE_OPT ||
                     reg_idx == IDX_LINE_TIMING || reg_idx == IDX_FRAME_BLANK ||
                     reg_idx == IDX_CONTROL || reg_idx == IDX_STATUS);

  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old_v,
                                             input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [REG_W-1:0] r;
    r = old_v;
    for (int b = 0; b < 3; b++)
    begin
      if (st[b])
        r[b*8 +: 8] = wd[b*8 +: 8];
    end
    return r;
  endfunction

  // Reserved bits are stored as written, except in the control register, which keeps bits 1:0 only; software keeps them at their set values [R2]
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sync_delay_q  <= RST_SYNC_DELAY;  // [R14]
      engine_opt_q  <= RST_ENGINE_OPT;  // [R14]
      line_timing_q <= RST_LINE_TIMING;  // [R14]
      frame_blank_q <= RST_FRAME_BLANK;  // [R14]
      control_q     <= RST_CONTROL[1:0];
    end
    else if (wr_en && rd_hit)
    begin
      case (reg_idx)
        IDX_SYNC_DELAY:  sync_delay_q  <= merge(sync_delay_q, pwdata_i, pstrb_i);
        IDX_ENGINE_OPT:  engine_opt_q  <= merge(engine_opt_q, pwdata_i, pstrb_i);
        IDX_LINE_TIMING: line_timing_q <= merge(line_timing_q, pwdata_i, pstrb_i);
        IDX_FRAME_BLANK: frame_blank_q <= merge(frame_blank_q, pwdata_i, pstrb_i);
        IDX_CONTROL:
        begin
          if (pstrb_i[0])
            control_q <= pwdata_i[1:0];
        end
        default: ;
      endcase
    end
  end

  // Read data stay combinational so a read needs no extra wait state
  // Status reads see the frame counter live; it may step during an access
  always_comb
  begin
    case (reg_idx)
      IDX_SYNC_DELAY:  prdata_o = {8'h00, sync_delay_q};
      IDX_ENGINE_OPT:  prdata_o = {8'h00, engine_opt_q};
      IDX_LINE_TIMING: prdata_o = {8'h00, line_timing_q};
      IDX_FRAME_BLANK: prdata_o = {8'h00, frame_blank_q};
      IDX_CONTROL:     prdata_o = {30'h0, control_q};
      IDX_STATUS:      prdata_o = {23'h0, frame_count_q, running};
      default:         prdata_o = 32'h0;
    endcase
    if (!rd_hit || !psel_i || pwrite_i)
      prdata_o = 32'h0;
  end

  // Refused accesses flag an error in the access phase only
  assign pslverr_o = psel_i && penable_i && !rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  logic [1:0]             col_log2;
  logic [1:0]             row_log2;
  logic [9:0]             act_len;
  logic [9:0]             blank_len;
  logic [5:0]             vblank;
  logic [5:0]             pulse_lines;
  logic [2:0]             pulse_code;
  logic [9:0]             cols_eff;
  logic [9:0]             rows_eff;
  logic [10:0]            line_last;
  logic [10:0]            frame_last;

  assign col_log2  = engine_opt_q[COL_BIN_LSB +: BIN_W];
  assign row_log2  = engine_opt_q[ROW_BIN_LSB +: BIN_W];
  assign act_len   = line_timing_q[LINE_ACTIVE_LSB +: LINE_W];  // [R10]
  assign blank_len = (line_timing_q[LINE_BLANK_LSB +: LINE_W] < LINE_BLANK_MIN) ?
                     LINE_BLANK_MIN : line_timing_q[LINE_BLANK_LSB +: LINE_W];  // [R9]
  assign vblank    = (frame_blank_q[VBLANK_LSB +: VBLANK_W] < VBLANK_MIN) ?
                     VBLANK_MIN : frame_blank_q[VBLANK_LSB +: VBLANK_W];  // [R13]
  assign pulse_code = line_timing_q[PULSE_CODE_LSB +: PULSE_CODE_W];
  // Codes 6 and 7 fall back to the four-line pulse
  assign pulse_lines = (pulse_code > PULSE_CODE_MAX) ? PULSE_LINES_DFLT :
                       (6'h01 << pulse_code);  // [R8]
  // Merge counts sent to the binning datapath
  assign column_bin_o = 4'h1 << col_log2;  // [R3]
  assign row_bin_o    = 4'h1 << row_log2;  // [R4]
  assign cols_eff = engine_opt_q[BIN_SIZE_BIT] ? act_len : (act_len >> col_log2);  // [R6]
  assign rows_eff = engine_opt_q[BIN_SIZE_BIT] ? ROWS : (ROWS >> row_log2);  // [R6]
  // Line period is active plus blank regardless of binning
  assign line_last  = 11'({1'b0, act_len} + {1'b0, blank_len} - 11'h1);  // [R10]
  assign frame_last = 11'({5'h0, vblank} + {1'b0, rows_eff} - 11'h1);

  ////////////////////////////////////////////////////////////////////////////
  // Pixel rate enable and frame sync delay
  logic [7:0] div_q;
  logic       pix_en;
  logic       synced_start;

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      div_q <= 8'h0;
    else if (div_q == DIV_LAST)
      div_q <= 8'h0;
    else
      div_q <= div_q + 8'h1;
  end

  // One-cycle pixel tick; line and frame timing is counted in these ticks, the sync delay in core_clk_i cycles
  assign pix_en = (div_q == DIV_LAST);
  assign pixel_clk_en_o = pix_en;

  // Pin is resynchronised inside; a new edge during a pending delay restarts it
  dop_sync_delay u_sync_delay (
    .core_clk_i   (core_clk_i),
    .rst_b_i      (rst_b_i),
    .ext_sync_i   (external_frame_sync_input_i),
    .delay_i      (sync_delay_q[SYNC_DELAY_LSB +: SYNC_DELAY_W]),
    .frame_sync_o (synced_start)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Timing generator
  dop_tg_state_t state_q;
  logic [10:0]   pix_q;
  logic [10:0]   line_q;
  logic          sync_restart;
  logic          in_rows;
  logic          in_cols;

  assign running      = (state_q == DOP_RUN);
  assign sync_restart = control_q[CTRL_SYNC_BIT] && synced_start;  // [R12]

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q       <= DOP_IDLE;
      pix_q         <= 11'h0;
      line_q        <= 11'h0;
      frame_count_q <= 8'h0;
    end
    else
    begin
      case (state_q)
        DOP_IDLE:
        begin
          pix_q  <= 11'h0;
          line_q <= 11'h0;
          if (control_q[CTRL_ENABLE_BIT])
            state_q <= DOP_RUN;
        end
        DOP_RUN:
        begin
          if (!control_q[CTRL_ENABLE_BIT])
            state_q <= DOP_IDLE;
          else if (sync_restart)
          begin
            // Delayed external sync realigns the frame at once [R12]
            pix_q         <= 11'h0;
            line_q        <= 11'h0;
            frame_count_q <= frame_count_q + 8'h1;
          end
          else if (pix_en)
          begin
            if (pix_q >= line_last)
            begin
              pix_q <= 11'h0;
              if (line_q >= frame_last)
              begin
                // No sync arrived: keep producing frames on own timing [R12]
                line_q        <= 11'h0;
                frame_count_q <= frame_count_q + 8'h1;
              end
              else
                line_q <= line_q + 11'h1;
            end
            else
              pix_q <= pix_q + 11'h1;
          end
        end
        default: state_q <= DOP_IDLE;
      endcase
    end
  end

  assign in_rows = (line_q >= {5'h0, vblank}) &&
                   (line_q < 11'({5'h0, vblank} + {1'b0, rows_eff}));  // [R13]
  assign in_cols = (pix_q < {1'b0, cols_eff});  // [R6]

  ////////////////////////////////////////////////////////////////////////////
  // Depth datapath and output registers
  logic [AMB_FLOOR_W-1:0] amb_floor;
  logic [SHIFT_AMT_W-1:0] shift_amt;
  logic [DATA_W-1:0]      phase_sel;
  logic [DATA_W-1:0]      pattern;

  assign amb_floor = engine_opt_q[AMB_FLOOR_LSB +: AMB_FLOOR_W];
  assign shift_amt = engine_opt_q[SHIFT_AMT_LSB +: SHIFT_AMT_W];
  // Amplitude passes untouched; only phase is suppressed in dark pixels
  assign phase_sel = (ambient_i < amb_floor) ? '0 : phase_i;  // [R7]
  assign pattern   = DATA_W'(pix_q ^ line_q);
  // Seven spare bits on scaled I and Q so even the largest shift cannot overflow

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      scaled_i_o <= '0;
      scaled_q_o <= '0;
    end
    else if (engine_opt_q[SHIFT_EN_BIT])
    begin
      scaled_i_o <= (DATA_W+7)'(raw_i_i) <<< shift_amt;  // [R5]
      scaled_q_o <= (DATA_W+7)'(raw_q_i) <<< shift_amt;  // [R5]
    end
    else
    begin
      scaled_i_o <= (DATA_W+7)'(raw_i_i);
      scaled_q_o <= (DATA_W+7)'(raw_q_i);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      frame_start_pulse_o <= 1'b0;
      line_start_pulse_o  <= 1'b0;
      pixel_valid_o       <= 1'b0;
      pixel_data_o        <= '0;
    end
    else
    begin
      frame_start_pulse_o <= running && (line_q < {5'h0, pulse_lines});  // [R8]
      line_start_pulse_o  <= running && in_rows && in_cols;  // [R10]
      pixel_valid_o       <= running && in_rows && in_cols && pix_en;
      if (running && in_rows && in_cols && pix_en)
      begin
        if (engine_opt_q[TEST_PAT_BIT])
          pixel_data_o <= {pattern, ~pattern};  // [R11]
        else
          pixel_data_o <= {amplitude_i, phase_sel};  // [R7]
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/dop_output_ctrl_props.sv
// Checker for the depth output block: register port and pixel port timing.
// Sees only top-level ports; bound from the testbench top file.
`timescale 1ns/1ns
`default_nettype none
module dop_output_ctrl_props
  import dop_pkg::*;
#(
  parameter int PIX_DIV = 4
)
(
  // Clock, reset and register port
  input  wire logic              core_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       prdata_o,
  input  wire logic              pslverr_o,
  // Depth and pixel port
  input  wire logic [3:0]        column_bin_o,
  input  wire logic [3:0]        row_bin_o,
  input  wire logic              frame_start_pulse_o,
  input  wire logic              line_start_pulse_o,
  input  wire logic              pixel_valid_o,
  input  wire logic              pixel_clk_en_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic       map_ok;
  logic [7:0] gap_q;
  logic       seen_q;
  assign map_ok = paddr_i[1:0] == 2'h0 && paddr_i[11:10] == 2'h0 && paddr_i[9:2] inside
    {IDX_SYNC_DELAY, IDX_ENGINE_OPT, IDX_LINE_TIMING, IDX_FRAME_BLANK, IDX_CONTROL, IDX_STATUS};
  // First pixel tick after reset has no earlier tick to measure against
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      gap_q <= 8'h00;
    else if (pixel_clk_en_o)
      gap_q <= 8'h00;
    else if (gap_q != 8'hff)
      gap_q <= gap_q + 8'h01;
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      seen_q <= 1'b0;
    else if (pixel_clk_en_o)
      seen_q <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  err_map_a: assert property (pslverr_o == (psel_i && penable_i && !map_ok))
    else $error("bus error flag disagrees with the address map");
  err_zero_a: assert property (psel_i && penable_i && !pwrite_i && pslverr_o |-> prdata_o == 32'h0)
    else $error("refused read returned data");
  col_bin_a: assert property (column_bin_o inside {4'h1, 4'h2, 4'h4, 4'h8})
    else $error("column merge count not a power of two up to 8");
  row_bin_a: assert property (row_bin_o inside {4'h1, 4'h2, 4'h4, 4'h8})
    else $error("row merge count not a power of two up to 8");
  pix_rate_a: assert property (pixel_clk_en_o && seen_q |-> gap_q == 8'(PIX_DIV - 1))
    else $error("pixel tick spacing wrong");
  pix_tick_a: assert property (pixel_valid_o |-> $past(pixel_clk_en_o) && line_start_pulse_o)
    else $error("pixel valid outside a tick or active line");
  pix_single_a: assert property (pixel_valid_o |=> !pixel_valid_o)
    else $error("pixel valid longer than one cycle");
  vblank_gap_a: assert property ($rose(frame_start_pulse_o) |-> !line_start_pulse_o [*8])
    else $error("line started too soon after frame start");
endmodule
`default_nettype wire

//--- tb/dop_host_rx.sv
// Host receiver model: measures line, frame and pulse timing on the pixel port.
// Assumes the port outputs are registered on core_clk_i.
`timescale 1ns/1ns
`default_nettype none
module dop_host_rx
(
  // Clock and pixel port
  input  wire logic core_clk_i,
  input  wire logic fs_i,
  input  wire logic ls_i,
  input  wire logic pv_i,
  // Measurements
  output int        line_pix_o,
  output int        line_per_o,
  output int        frame_lines_o,
  output int        pulse_cyc_o,
  output int        gap_cyc_o
);
  int   pix = 0, lp = 0, fl = 0, pc = 0, gc = 0;
  logic fs_q = 1'b0, ls_q = 1'b0, seek = 1'b0;
  always @(posedge core_clk_i)
  begin
    fs_q <= fs_i;
    ls_q <= ls_i;
    pc <= fs_i ? pc + 1 : 0;
    gc <= gc + 1;
    lp <= lp + 1;
    if (pv_i && ls_i)
      pix <= pix + 1;
    if (!fs_i && fs_q)
      pulse_cyc_o <= pc;
    if (fs_i && !fs_q)
    begin
      frame_lines_o <= fl;
      fl <= 0;
      gc <= 1;
      seek <= 1'b1;
    end
    if (ls_i && !ls_q)
    begin
      line_per_o <= lp;
      lp <= 1;
      fl <= fl + 1;
      if (seek)
        gap_cyc_o <= gc;
      seek <= 1'b0;
    end
    if (!ls_i && ls_q)
    begin
      line_pix_o <= pix;
      pix <= 0;
    end
  end
endmodule
`default_nettype wire

//--- tb/dop_output_ctrl_tb.sv
// Testbench for the depth output block: registers, data path and pixel port.
// Uses the host receiver model and the bound checker; one 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module dop_output_ctrl_tb;
  import dop_pkg::*;
  logic               core_clk_i = 0, rst_b_i = 0, psel_i = 0, penable_i = 0;
  logic               pwrite_i = 0, ext_i = 0, pready_o, pslverr_o;
  logic               fs_o, ls_o, pv_o, pce_o;
  logic [11:0]        paddr_i = '0, ph = 12'h123, amp = 12'habc;
  logic [31:0]        pwdata_i = '0, prdata_o;
  logic signed [11:0] raw_i = 12'sd5, raw_q = -12'sd3;
  logic [3:0]         amb = 4'h5, cb_o, rb_o;
  logic signed [18:0] si_o, sq_o;
  logic [23:0]        pd_o;
  int                 lpix, lper, flines, pcyc, gcyc, err_count = 0, num_checks = 0, cyc = 0;
  always #5 core_clk_i = ~core_clk_i;
  dop_output_ctrl #(.PIX_DIV(4), .FRAME_ROWS(4), .DATA_W(12)) uut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hf),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .external_frame_sync_input_i(ext_i), .raw_i_i(raw_i), .raw_q_i(raw_q), .phase_i(ph),
    .amplitude_i(amp), .ambient_i(amb), .scaled_i_o(si_o), .scaled_q_o(sq_o),
    .column_bin_o(cb_o), .row_bin_o(rb_o), .frame_start_pulse_o(fs_o),
    .line_start_pulse_o(ls_o), .pixel_valid_o(pv_o), .pixel_data_o(pd_o),
    .pixel_clk_en_o(pce_o));
  dop_host_rx host (.core_clk_i(core_clk_i), .fs_i(fs_o), .ls_i(ls_o), .pv_i(pv_o),
    .line_pix_o(lpix), .line_per_o(lper), .frame_lines_o(flines), .pulse_cyc_o(pcyc),
    .gap_cyc_o(gcyc));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Idle edge at the end keeps back-to-back calls from driving twice at once
  task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= {2'b00, ix, 2'b00};
    pwdata_i <= wd;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do
      @(posedge core_clk_i);
    while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [7:0] ix, input logic [23:0] v);
    logic [31:0] r;
    logic        e;
    apb(1'b1, ix, {8'h00, v}, r, e);
  endtask
  task automatic frames(input int k);
    repeat (k) @(posedge fs_o);
    @(posedge core_clk_i);
  endtask
  task automatic grab(output logic [23:0] d);
    repeat (2)
    begin
      @(negedge core_clk_i);
      while (pv_o !== 1'b1)
        @(negedge core_clk_i);
    end
    d = pd_o;
    @(posedge core_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    logic [7:0]  ix[3] = '{IDX_SYNC_DELAY, IDX_ENGINE_OPT, IDX_LINE_TIMING};
    logic [23:0] rv[3] = '{24'h400001, 24'h00000c, 24'h480280};
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b0, ix[k], 32'h0, r, e);
      chk("reset_word", r, {8'h00, rv[k]});
    end
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk("unmapped_err", 32'(e), 32'h1);
    wr(IDX_SYNC_DELAY, 24'h400007);
    apb(1'b0, IDX_SYNC_DELAY, 32'h0, r, e);
    chk("sync_readback", r, 32'h00400007);
  endtask
  task automatic t_bins;
    for (int v = 0; v < 4; v++)
    begin
      wr(IDX_ENGINE_OPT, {2'b00, 2'(v), 2'(v), 18'h00008});
      chk("col_bin", 32'(cb_o), 32'(1 << v));
      chk("row_bin", 32'(rb_o), 32'(1 << v));
    end
  endtask
  task automatic t_scale;
    for (int k = 0; k < 16; k++)
    begin
      wr(IDX_ENGINE_OPT, {7'h00, 1'(k >> 3), 13'h0001, 3'(k)});
      // Scaled outputs are registered one edge after the option word lands
      @(posedge core_clk_i);
      chk("scaled_i", 32'(si_o), 32'(k > 7 ? 19'sd5 <<< k[2:0] : 19'sd5));
      chk("scaled_q", 32'(sq_o), 32'(k > 7 ? -19'sd3 <<< k[2:0] : -19'sd3));
    end
  endtask
  // Blank of 33 lines keeps the longest frame pulse clear of the first line
  task automatic t_pulse;
    int n[8] = '{1, 2, 4, 8, 16, 32, 4, 4};
    wr(IDX_FRAME_BLANK, 24'h01c23c);
    wr(IDX_CONTROL, 24'h000001);
    for (int c = 0; c < 8; c++)
    begin
      wr(IDX_LINE_TIMING, {3'(c), 10'd2, 10'd8, 1'b0});
      frames(3);
      chk("pulse_cycles", pcyc, n[c] * 40);
      chk("line_period", lper, 40);
      chk("line_pixels", lpix, 8);
      chk("frame_lines", flines, 4);
      chk("blank_gap", gcyc, 33 * 40);
    end
  endtask
  task automatic t_size;
    wr(IDX_ENGINE_OPT, 24'h140008);
    frames(3);
    chk("binned_pixels", lpix, 4);
    chk("binned_lines", flines, 2);
    wr(IDX_ENGINE_OPT, 24'h148008);
    frames(3);
    chk("kept_pixels", lpix, 8);
    chk("kept_lines", flines, 4);
  endtask
  task automatic t_data;
    logic [23:0] d;
    wr(IDX_ENGINE_OPT, 24'h000148);
    grab(d);
    chk("pixel_data", 32'(d), 32'h00abc123);
    wr(IDX_ENGINE_OPT, 24'h000188);
    grab(d);
    chk("zeroed_phase", 32'(d), 32'h00abc000);
    wr(IDX_ENGINE_OPT, 24'h004008);
    grab(d);
    chk("test_pattern", 32'(d[23:12] ^ d[11:0]), 32'h00000fff);
  endtask
  task automatic sync_lat(input logic [21:0] dly, output int n);
    wr(IDX_SYNC_DELAY, {2'b01, dly});
    @(negedge fs_o);
    @(posedge core_clk_i);
    ext_i <= 1'b1;
    n = 0;
    do
    begin
      @(negedge core_clk_i);
      n++;
    end
    while (fs_o !== 1'b1);
    @(posedge core_clk_i);
    ext_i <= 1'b0;
  endtask
  task automatic t_sync;
    int a, b;
    wr(IDX_LINE_TIMING, {3'd0, 10'd2, 10'd8, 1'b0});
    wr(IDX_CONTROL, 24'h000003);
    sync_lat(22'd1, a);
    sync_lat(22'd20, b);
    chk("sync_delay_step", b - a, 19);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      err_count++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (10) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    t_regs;
    t_bins;
    t_scale;
    t_pulse;
    t_size;
    t_data;
    t_sync;
    end_of_test;
  end
endmodule
bind dop_output_ctrl dop_output_ctrl_props #(.PIX_DIV(PIX_DIV)) chk_u (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
  .column_bin_o(column_bin_o), .row_bin_o(row_bin_o),
  .frame_start_pulse_o(frame_start_pulse_o), .line_start_pulse_o(line_start_pulse_o),
  .pixel_valid_o(pixel_valid_o), .pixel_clk_en_o(pixel_clk_en_o));
`default_nettype wire
